// ==== hdl/otc_cmp.sv ====
`timescale 1ns/1ps
module otc_cmp
    import otc_pkg::*;
#(
    parameter int HYST = HYST_CODES
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Limit and reading in, flag and events out
    otc_cmp_if.cmp   cb
);
    localparam int SW = ADC_W + 1;

    logic          flag_ff;
    logic          rise_ff;
    logic          fall_ff;
    logic          nxt_flag;
    logic          nxt_rise;
    logic          nxt_fall;
    logic [SW-1:0] release_lvl;

    assign release_lvl = SW'(cb.limit) + SW'(HYST);

    always_comb begin
        nxt_flag = flag_ff;
        nxt_rise = 1'b0;
        nxt_fall = 1'b0;
        if (cb.sample_valid) begin
            if (!flag_ff && (SW'(cb.sample) < SW'(cb.limit))) begin
                nxt_flag = 1'b1;
                nxt_rise = 1'b1;
            end else if (flag_ff && (SW'(cb.sample) >= release_lvl)) begin
                nxt_flag = 1'b0;
                nxt_fall = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            flag_ff <= 1'b0;
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
        end else if (ce) begin
            flag_ff <= nxt_flag;
            rise_ff <= nxt_rise;
            fall_ff <= nxt_fall;
        end
    end

    assign cb.flag = flag_ff;
    assign cb.rise = rise_ff;
    assign cb.fall = fall_ff;
endmodule

// ==== hdl/otc_cmp_if.sv ====
`timescale 1ns/1ps
interface otc_cmp_if #(
    parameter int LIM_W = 8,
    parameter int ADC_W = 9
);
    logic [LIM_W-1:0] limit;
    logic [ADC_W-1:0] sample;
    logic             sample_valid;
    logic             flag;
    logic             rise;
    logic             fall;

    modport ctl (output limit, output sample, output sample_valid,
                 input flag, input rise, input fall);
    modport cmp (input limit, input sample, input sample_valid,
                 output flag, output rise, output fall);
endinterface

// ==== hdl/otc_pkg.sv ====
package otc_pkg;

    // Scale of the limit code and the converter reading, in microvolts
    localparam int STEP_UV    = 3040;
    localparam int LIM_MIN_UV = 9120;
    localparam int LIM_MAX_UV = 760000;
    localparam int HYST_UV    = 16000;
    localparam int ADC_FS_UV  = 1550000;

    // Reading shares the limit LSB, so full scale needs more bits than the limit
    localparam int LIM_W      = 8;
    localparam int ADC_W      = $clog2(ADC_FS_UV / STEP_UV + 1);
    // Release margin rounds up so the flag never clears early
    localparam int HYST_CODES = (HYST_UV + STEP_UV - 1) / STEP_UV;
    localparam logic [LIM_W-1:0] LIM_MIN = LIM_W'(LIM_MIN_UV / STEP_UV);
    localparam logic [LIM_W-1:0] LIM_MAX = LIM_W'(LIM_MAX_UV / STEP_UV);

    // Register indices; byte address is four times the index
    localparam int          IDX_W        = 8;
    localparam logic [7:0]  IDX_ADC      = 8'h1A;
    localparam logic [7:0]  IDX_LIMIT    = 8'h2F;
    localparam logic [7:0]  IDX_IRQ_STAT = 8'h40;
    localparam logic [7:0]  IDX_IRQ_MASK = 8'h41;
    localparam logic [7:0]  IDX_STATUS   = 8'h42;
    localparam int          IDX_LSB      = 2;
    localparam int          MAP_TOP      = IDX_LSB + IDX_W;

    localparam logic [LIM_W-1:0] LIMIT_RST = 8'h03;

    // Interrupt and status bit positions
    localparam int IRQ_W     = 2;
    localparam int IRQ_SET   = 0;
    localparam int IRQ_CLR   = 1;
    localparam int ST_FLAG   = 0;
    localparam int ST_RANGE  = 1;

    localparam int          TRANS_ACT = 1;
    localparam logic [1:0]  RESP_OKAY = 2'h0;

endpackage

// ==== hdl/otc_top.sv ====
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module otc_top
    import otc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              REF_CLK,
    input  wire logic              SRST,
    input  wire logic              CE,
    // AHB-Lite slave
    input  wire logic              HSEL,
    input  wire logic [31:0]       HADDR,
    input  wire logic [1:0]        HTRANS,
    input  wire logic              HWRITE,
    input  wire logic [2:0]        HSIZE,
    input  wire logic [31:0]       HWDATA,
    input  wire logic              HREADY,
    output logic      [31:0]       HRDATA,
    output logic                   HREADYOUT,
    output logic                   HRESP,
    // Temperature-sense converter
    input  wire logic [ADC_W-1:0]  TS_SAMPLE,
    input  wire logic              TS_VALID,
    // Flag and interrupt
    output logic                   OT_FLAG,
    output logic                   IRQ
);

    otc_cmp_if #(.LIM_W(LIM_W), .ADC_W(ADC_W)) cbus ();

    // Address-phase capture
    logic             wr_pend_ff;
    logic [IDX_W-1:0] wr_idx_ff;
    logic             nxt_wr_pend;
    logic [IDX_W-1:0] nxt_wr_idx;

    // Read data
    logic [31:0]      rdata_ff;
    logic [31:0]      nxt_rdata;
    logic [31:0]      rd_word;
    logic [31:0]      status_word;

    // Limit and its range check
    logic [LIM_W-1:0] limit_ff;
    logic [LIM_W-1:0] nxt_limit;
    logic             range_ff;
    logic             nxt_range;

    // Latest sample
    logic [ADC_W-1:0] sample_ff;
    logic [ADC_W-1:0] nxt_sample;

    // Interrupt state
    logic [IRQ_W-1:0] mask_ff;
    logic [IRQ_W-1:0] nxt_mask;
    logic [IRQ_W-1:0] stat_ff;
    logic [IRQ_W-1:0] nxt_stat;
    logic [IRQ_W-1:0] irq_src;
    logic             irq_ff;
    logic             nxt_irq;

    // Bus response
    logic             hreadyout_ff;
    logic             nxt_hreadyout;
    logic             hresp_ff;
    logic             nxt_hresp;

    // Decode
    logic             addr_ok;
    logic             rd_take;
    logic             wr_take;
    logic             mapped;
    logic [IDX_W-1:0] a_idx;
    logic             wr_limit;
    logic             wr_mask;
    logic             wr_stat;
    logic [IRQ_W-1:0] evt;

    assign addr_ok = HSEL && HTRANS[TRANS_ACT] && HREADY;
    assign rd_take = addr_ok && !HWRITE;
    assign wr_take = addr_ok && HWRITE;
    assign a_idx   = HADDR[MAP_TOP-1:IDX_LSB];
    assign mapped  = (HADDR[31:MAP_TOP] == '0) && (HADDR[IDX_LSB-1:0] == 2'h0);

    // Comparator sees the live reading so the flag moves at the sampling edge
    assign cbus.limit        = limit_ff;
    assign cbus.sample       = TS_SAMPLE;
    assign cbus.sample_valid = TS_VALID;

    otc_cmp u_cmp (
        .clk  (REF_CLK),
        .srst (SRST),
        .ce   (CE),
        .cb   (cbus)
    );

    always_comb begin
        evt          = '0;
        evt[IRQ_SET] = cbus.rise;
        evt[IRQ_CLR] = cbus.fall;
    end

    // Address phase: zero wait states, so a write lands when its data phase ends
    always_comb begin
        nxt_wr_pend = 1'b0;
        nxt_wr_idx  = wr_idx_ff;
        if (wr_take) begin
            nxt_wr_pend = mapped;
            nxt_wr_idx  = a_idx;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff  <= '0;
        end else if (CE) begin
            wr_pend_ff <= nxt_wr_pend;
            wr_idx_ff  <= nxt_wr_idx;
        end
    end

    // Write strobes; read-only and unmapped indices fall to default
    always_comb begin
        wr_limit = 1'b0;
        wr_mask  = 1'b0;
        wr_stat  = 1'b0;
        if (wr_pend_ff) begin
            unique case (wr_idx_ff)
                IDX_LIMIT:    wr_limit = 1'b1;
                IDX_IRQ_MASK: wr_mask  = 1'b1;
                IDX_IRQ_STAT: wr_stat  = 1'b1;
                default:      wr_limit = 1'b0;
            endcase
        end
    end

    always_comb begin
        status_word           = '0;
        status_word[ST_FLAG]  = cbus.flag;
        status_word[ST_RANGE] = range_ff;
    end

    // Word for the address now on the bus; narrow fields sit in the low bits
    always_comb begin
        rd_word = '0;
        if (mapped) begin
            unique case (a_idx)
                IDX_ADC:      rd_word = 32'(sample_ff);
                IDX_LIMIT:    rd_word = 32'(limit_ff);
                IDX_IRQ_STAT: rd_word = 32'(stat_ff);
                IDX_IRQ_MASK: rd_word = 32'(mask_ff);
                IDX_STATUS:   rd_word = status_word;
                default:      rd_word = '0;
            endcase
        end
    end

    // Read data stands until the next taken address phase
    always_comb begin
        nxt_rdata = rdata_ff;
        if (rd_take) begin
            nxt_rdata = rd_word;
        end else if (wr_take) begin
            nxt_rdata = '0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            rdata_ff <= '0;
        end else if (CE) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Limit
    always_comb begin
        nxt_limit = limit_ff;
        if (wr_limit) begin
            nxt_limit = HWDATA[LIM_W-1:0];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            limit_ff <= LIMIT_RST;
        end else if (CE) begin
            limit_ff <= nxt_limit;
        end
    end

    // Codes outside the usable span still compare, but software can see it
    always_comb begin
        nxt_range = (nxt_limit >= LIM_MIN) && (nxt_limit <= LIM_MAX);
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            range_ff <= (LIMIT_RST >= LIM_MIN) && (LIMIT_RST <= LIM_MAX);
        end else if (CE) begin
            range_ff <= nxt_range;
        end
    end

    // Latest converter sample, kept for software
    always_comb begin
        nxt_sample = sample_ff;
        if (TS_VALID) begin
            nxt_sample = TS_SAMPLE;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            sample_ff <= '0;
        end else if (CE) begin
            sample_ff <= nxt_sample;
        end
    end

    // Interrupt mask
    always_comb begin
        nxt_mask = mask_ff;
        if (wr_mask) begin
            nxt_mask = HWDATA[IRQ_W-1:0];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            mask_ff <= '0;
        end else if (CE) begin
            mask_ff <= nxt_mask;
        end
    end

    // Status: a hardware set beats a same-cycle write-one clear
    always_comb begin
        nxt_stat = stat_ff;
        if (wr_stat) begin
            nxt_stat = stat_ff & ~HWDATA[IRQ_W-1:0];
        end
        nxt_stat = nxt_stat | evt;
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            stat_ff <= '0;
        end else if (CE) begin
            stat_ff <= nxt_stat;
        end
    end

    // Interrupt taken from next status and mask so it moves with them
    always_comb begin
        irq_src = nxt_stat & nxt_mask;
        nxt_irq = |irq_src;
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            irq_ff <= 1'b0;
        end else if (CE) begin
            irq_ff <= nxt_irq;
        end
    end

    // Never stalls; still a flop so every output is registered
    always_comb begin
        nxt_hreadyout = 1'b1;
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            hreadyout_ff <= 1'b1;
        end else begin
            hreadyout_ff <= nxt_hreadyout;
        end
    end

    // Never errors
    always_comb begin
        nxt_hresp = RESP_OKAY[0];
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            hresp_ff <= RESP_OKAY[0];
        end else begin
            hresp_ff <= nxt_hresp;
        end
    end

    assign HRDATA    = rdata_ff;
    assign HREADYOUT = hreadyout_ff;
    assign HRESP     = hresp_ff;
    assign OT_FLAG   = cbus.flag;
    assign IRQ       = irq_ff;

endmodule

// ==== testbench/otc_top_asserts.sv ====
`timescale 1ns/1ps
module otc_top_asserts
    import otc_pkg::*;
(
    // Clock, reset and enable
    input wire logic             REF_CLK,
    input wire logic             SRST,
    input wire logic             CE,
    // Bus
    input wire logic             HSEL,
    input wire logic [31:0]      HADDR,
    input wire logic [1:0]       HTRANS,
    input wire logic             HWRITE,
    input wire logic [31:0]      HWDATA,
    input wire logic             HREADY,
    input wire logic [31:0]      HRDATA,
    input wire logic             HREADYOUT,
    input wire logic             HRESP,
    // Converter and flag
    input wire logic [ADC_W-1:0] TS_SAMPLE,
    input wire logic             TS_VALID,
    input wire logic             OT_FLAG
);
    logic             wr_ff;
    logic             nxt_wr;
    logic [LIM_W-1:0] lim_ff;
    logic [LIM_W-1:0] nxt_lim;
    logic             acc;
    logic             smp;
    logic [ADC_W-1:0] lim;
    logic [ADC_W-1:0] rel;
    // Shadow of the limit, tracked from bus writes to its address
    assign acc = HSEL && HTRANS[1] && HREADY && CE && HADDR == 32'h0000_00BC;
    assign smp = CE && TS_VALID;
    assign lim = ADC_W'(lim_ff);
    assign rel = lim + ADC_W'(HYST_CODES);
    always_comb begin
        nxt_wr  = CE ? acc && HWRITE : wr_ff;
        nxt_lim = (wr_ff && CE) ? HWDATA[7:0] : lim_ff;
    end
    always_ff @(posedge REF_CLK) begin
        wr_ff  <= SRST ? 1'b0 : nxt_wr;
        lim_ff <= SRST ? LIMIT_RST : nxt_lim;
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    set_below_a: assert property (smp && !OT_FLAG && TS_SAMPLE < lim |=> OT_FLAG)
        else $error("flag not set below limit");
    stay_clear_a: assert property (smp && !OT_FLAG && TS_SAMPLE >= lim |=> !OT_FLAG)
        else $error("flag set at or above limit");
    hyst_hold_a: assert property (smp && OT_FLAG && TS_SAMPLE < rel |=> OT_FLAG)
        else $error("flag cleared inside margin");
    hyst_clear_a: assert property (smp && OT_FLAG && TS_SAMPLE >= rel |=> !OT_FLAG)
        else $error("flag kept past margin");
    flag_hold_a: assert property (!smp |=> $stable(OT_FLAG))
        else $error("flag moved without sample");
    limit_read_a: assert property (acc && !HWRITE |=> HRDATA == {24'h0, $past(lim_ff)})
        else $error("limit readback wrong");
    bus_okay_a: assert property (HREADYOUT && !HRESP)
        else $error("bus not ready or error");
    flag_change_a: assert property ($changed(OT_FLAG) |-> $past(smp))
        else $error("flag changed with no sample");
endmodule
bind otc_top otc_top_asserts chk_i (.REF_CLK(REF_CLK), .SRST(SRST), .CE(CE), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TS_SAMPLE(TS_SAMPLE),
    .TS_VALID(TS_VALID), .OT_FLAG(OT_FLAG));

// ==== testbench/overtemp_threshold_compare_bench.sv ====
`timescale 1ns/1ps
module overtemp_threshold_compare_bench import otc_pkg::*;;
    logic             ref_clk, srst, ce, hsel, hwrite, ts_valid, hreadyout, ot_flag, irq;
    logic [1:0]       htrans;
    logic [31:0]      haddr, hwdata, hrdata, rd;
    logic [ADC_W-1:0] ts_sample;
    logic [7:0]       codes [4] = '{8'h02, 8'h03, 8'hFA, 8'hFB};
    int               bad_count, cmp_count, cyc;
    otc_top uut (.REF_CLK(ref_clk), .SRST(srst), .CE(ce), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(), .TS_SAMPLE(ts_sample),
        .TS_VALID(ts_valid), .OT_FLAG(ot_flag), .IRQ(irq));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Address phase, then data phase; read data taken at the closing edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= a;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Stale reading is inverted once valid drops, so nothing leans on it
    task automatic samp(input logic [ADC_W-1:0] v, input logic e);
        ts_valid  <= 1'b1;
        ts_sample <= v;
        ce        <= e;
        @(posedge ref_clk);
        ts_valid  <= 1'b0;
        ts_sample <= ~v;
        ce        <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        {srst, ce, hsel, hwrite, ts_valid} = 5'b11100;
        {htrans, haddr, hwdata, ts_sample} = '0;
        {bad_count, cmp_count, cyc} = '0;
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        xfer(1'b0, 32'h0000_00BC, 32'h0);
        chk(rd, 32'h0000_0003);
        xfer(1'b0, 32'h0000_03FC, 32'h0);
        chk(rd, 32'h0);
        $display("test 1 done");
        foreach (codes[i]) begin
            xfer(1'b1, 32'h0000_00BC, 32'hFFFF_FF00 | codes[i]);
            xfer(1'b0, 32'h0000_00BC, 32'h0);
            chk(rd, {24'h0, codes[i]});
            xfer(1'b0, 32'h0000_0108, 32'h0);
            chk(rd[1], codes[i] >= 8'h03 && codes[i] <= 8'hFA);
        end
        $display("test 2 done");
        xfer(1'b1, 32'h0000_00BC, 32'h64);
        xfer(1'b1, 32'h0000_0104, 32'h3);
        samp(9'd100, 1'b1);
        chk({irq, ot_flag}, 32'h0);
        samp(9'd99, 1'b1);
        chk({irq, ot_flag}, 32'h3);
        samp(9'd100 + 9'(HYST_CODES) - 9'd1, 1'b1);
        chk(ot_flag, 32'h1);
        samp(9'd100 + 9'(HYST_CODES), 1'b1);
        chk(ot_flag, 32'h0);
        xfer(1'b0, 32'h0000_0100, 32'h0);
        chk(rd, 32'h3);
        xfer(1'b1, 32'h0000_0100, 32'h3);
        xfer(1'b1, 32'h0000_0104, 32'h0);
        samp(9'd50, 1'b1);
        chk({irq, ot_flag}, 32'h1);
        $display("test 3 done");
        samp(9'h1FF, 1'b0);
        chk(ot_flag, 32'h1);
        xfer(1'b0, 32'h0000_0068, 32'h0);
        chk(rd, 32'h32);
        samp(9'h1FF, 1'b1);
        chk(ot_flag, 32'h0);
        xfer(1'b0, 32'h0000_0068, 32'h0);
        chk(rd, 32'h1FF);
        $display("test 4 done");
        samp(9'd50, 1'b1);
        chk(ot_flag, 32'h1);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        chk({irq, ot_flag}, 32'h0);
        xfer(1'b0, 32'h0000_00BC, 32'h0);
        chk(rd, 32'h0000_0003);
        xfer(1'b0, 32'h0000_0100, 32'h0);
        chk(rd, 32'h0);
        $display("test 5 done");
        end_of_test();
    end
endmodule
